// >>> nrps_defines.svh
`ifndef NRPS_DEFINES_SVH
`define NRPS_DEFINES_SVH

// ----------------------------------------
// Software register offsets (byte address)
// ----------------------------------------
`define NRPS_OFS_CTRL 4'h0
`define NRPS_OFS_ADDR_LO 4'h4
`define NRPS_OFS_ADDR_HI 4'h8
`define NRPS_OFS_DATA 4'hC

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define NRPS_CTRL_GO_BIT 0
`define NRPS_CTRL_OP_LSB 4
`define NRPS_CTRL_OP_MSB 7
`define NRPS_CTRL_EDO_BIT 8
`define NRPS_CTRL_WPN_BIT 9
`define NRPS_CTRL_4GB_BIT 10

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define NRPS_STAT_BUSY_BIT 16
`define NRPS_STAT_RB_BIT 17
`define NRPS_STAT_SR_LSB 24

// ----------------------------------------
// Flash command codes
// ----------------------------------------
`define NRPS_CMD_READ 8'h00
`define NRPS_CMD_READ_GO 8'h30
`define NRPS_CMD_COL_CHG 8'h05
`define NRPS_CMD_COL_GO 8'hE0
`define NRPS_CMD_CACHE_NEXT 8'h31
`define NRPS_CMD_CACHE_LAST 8'h3F
`define NRPS_CMD_STATUS 8'h70
`define NRPS_CMD_PROG 8'h80
`define NRPS_CMD_PROG_COL 8'h85
`define NRPS_CMD_PROG_GO 8'h10

// ----------------------------------------
// Geometry and status bits
// ----------------------------------------
`define NRPS_PAGE_BYTES 12'h870
`define NRPS_PAGES_PER_BLOCK 7'h40
`define NRPS_SR_PASS_FAIL 0
`define NRPS_SR_CHIP_IDLE 5
`define NRPS_SR_CACHE_READY 6

// ----------------------------------------
// Strobe timing, ns and cycles at 50 ns
// ----------------------------------------
`define NRPS_CLK_NS 50
`define NRPS_STROBE_NS 50
`define NRPS_STROBE_CYC (((`NRPS_STROBE_NS + `NRPS_CLK_NS - 1) / `NRPS_CLK_NS))

`endif

// >>> nrps_pkg.sv
package nrps_pkg;
   typedef enum logic [3:0] {
      NRPS_OP_PAGE_READ = 4'h0,
      NRPS_OP_COL_CHANGE = 4'h1,
      NRPS_OP_CACHE_SEQ = 4'h2,
      NRPS_OP_CACHE_RAND = 4'h3,
      NRPS_OP_CACHE_LAST = 4'h4,
      NRPS_OP_STATUS = 4'h5,
      NRPS_OP_RESUME = 4'h6,
      NRPS_OP_PROG_START = 4'h7,
      NRPS_OP_PROG_COL = 4'h8,
      NRPS_OP_PROG_GO = 4'h9,
      NRPS_OP_READ_BYTE = 4'hA,
      NRPS_OP_WRITE_BYTE = 4'hB
   } nrps_op_t;

   typedef enum logic [1:0] {
      NRPS_CYC_CMD,
      NRPS_CYC_ADDR,
      NRPS_CYC_DIN,
      NRPS_CYC_DOUT
   } nrps_cyc_t;
endpackage

// >>> nrps_addr_fmt.sv
`timescale 1ns/1ps
`include "nrps_defines.svh"
module nrps_addr_fmt (
   input wire logic [11:0] i_col,
   input wire logic [17:0] i_row,
   input wire logic i_is_4gb,
   input wire logic [2:0] i_idx,
   output logic [7:0] o_byte
);
   logic [7:0] cyc5;
   assign cyc5 = {6'h00, i_row[17] & i_is_4gb, i_row[16]};
   assign o_byte = (i_idx == 3'h0) ? i_col[7:0] :
                   (i_idx == 3'h1) ? {4'h0, i_col[11:8]} :
                   (i_idx == 3'h2) ? i_row[7:0] :
                   (i_idx == 3'h3) ? i_row[15:8] : cyc5;
endmodule

// >>> nrps_strobe.sv
`timescale 1ns/1ps
`include "nrps_defines.svh"
module nrps_strobe (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_start,
   output logic o_low,
   output logic o_done
);
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic [1:0] ph_reg;
   logic [1:0] ph_next;
   // Phase 1 strobe low, phase 2 strobe high, then done
   assign o_low = (ph_reg == 2'h1);
   assign o_done = (ph_reg == 2'h2) && (cnt_reg == 2'h0);
   always_comb begin
      ph_next = ph_reg;
      cnt_next = cnt_reg;
      if (i_start && ph_reg == 2'h0) begin
         ph_next = 2'h1;
         cnt_next = 2'(`NRPS_STROBE_CYC - 1);
      end else if (ph_reg != 2'h0 && cnt_reg != 2'h0) begin
         cnt_next = cnt_reg - 2'h1;
      end else if (ph_reg == 2'h1) begin
         ph_next = 2'h2;
         cnt_next = 2'(`NRPS_STROBE_CYC - 1);
      end else if (ph_reg == 2'h2) begin
         ph_next = 2'h0;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ph_reg <= 2'h0;
         cnt_reg <= 2'h0;
      end else if (i_ce) begin
         ph_reg <= ph_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule

// >>> nrps_host.sv
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "nrps_defines.svh"
module nrps_host
   import nrps_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_ce_n,
   output logic o_cle,
   output logic o_ale,
   output logic o_we_n,
   output logic o_read_strobe_n,
   output logic o_wp_n,
   input wire logic [7:0] i_io,
   output logic [7:0] o_io,
   output logic o_io_oe,
   input wire logic i_rb_n
);
   import nrps_pkg::*;

   typedef enum logic [2:0] {
      NRPS_ST_IDLE,
      NRPS_ST_CYCLE,
      NRPS_ST_NEXT,
      NRPS_ST_WAIT_RB,
      NRPS_ST_DONE
   } nrps_state_t;

   // ----------------------------------------
   // Step table: each op is a list of bus cycles
   // ----------------------------------------
   function automatic logic [11:0] step_of(input nrps_op_t op, input logic [2:0] n);
      // Returns {last, kind[1:0], wait_rb, addr_idx[2:0], cmd_sel[4:0]}
      logic [11:0] r;
      r = 12'h000;
      unique case (op)
         // Command, five address bytes, then confirm
         // Program start stops after the address; data bytes follow
         NRPS_OP_PAGE_READ, NRPS_OP_CACHE_RAND, NRPS_OP_PROG_START:
            r = (n == 3'h0) ? {1'b0, 2'h0, 1'b0, 3'h0, 5'h0} :
                (n <= 3'h5) ? {(op == NRPS_OP_PROG_START) && (n == 3'h5), 2'h1, 1'b0,
                               n - 3'h1, 5'h0} :
                {1'b1, 2'h0, (op != NRPS_OP_PROG_START), 3'h0, 5'h1};
         // Two column bytes; only the read variant confirms
         NRPS_OP_COL_CHANGE, NRPS_OP_PROG_COL:
            r = (n == 3'h0) ? {1'b0, 2'h0, 1'b0, 3'h0, 5'h2} :
                (n <= 3'h2) ? {(op == NRPS_OP_PROG_COL) && (n == 3'h2), 2'h1, 1'b0,
                               n - 3'h1, 5'h0} :
                {1'b1, 2'h0, 1'b0, 3'h0, 5'h3};
         // Cache confirms wait out the page transfer
         NRPS_OP_CACHE_SEQ: r = {1'b1, 2'h0, 1'b1, 3'h0, 5'h4};
         NRPS_OP_CACHE_LAST: r = {1'b1, 2'h0, 1'b1, 3'h0, 5'h5};
         // Status read; a later resume sends the read command again
         NRPS_OP_STATUS: r = (n == 3'h0) ? {1'b0, 2'h0, 1'b0, 3'h0, 5'h6} :
                                           {1'b1, 2'h3, 1'b0, 3'h0, 5'h0};
         NRPS_OP_RESUME: r = {1'b1, 2'h0, 1'b0, 3'h0, 5'h0};
         NRPS_OP_PROG_GO: r = {1'b1, 2'h0, 1'b1, 3'h0, 5'h7};
         NRPS_OP_READ_BYTE: r = {1'b1, 2'h3, 1'b0, 3'h0, 5'h0};
         NRPS_OP_WRITE_BYTE: r = {1'b1, 2'h2, 1'b0, 3'h0, 5'h0};
         default: r = {1'b1, 2'h0, 1'b0, 3'h0, 5'h0};
      endcase
      return r;
   endfunction

   // Command byte per step; unknown selectors fall back to a read
   function automatic logic [7:0] cmd_code(input logic [4:0] s, input nrps_op_t op);
      logic [7:0] c;
      c = `NRPS_CMD_READ;
      unique case (s)
         5'h0: c = (op == NRPS_OP_PROG_START) ? `NRPS_CMD_PROG : `NRPS_CMD_READ;
         5'h1: c = (op == NRPS_OP_PAGE_READ) ? `NRPS_CMD_READ_GO :
                   (op == NRPS_OP_CACHE_RAND) ? `NRPS_CMD_CACHE_NEXT : `NRPS_CMD_READ;
         5'h2: c = (op == NRPS_OP_PROG_COL) ? `NRPS_CMD_PROG_COL : `NRPS_CMD_COL_CHG;
         5'h3: c = `NRPS_CMD_COL_GO;
         5'h4: c = `NRPS_CMD_CACHE_NEXT;
         5'h5: c = `NRPS_CMD_CACHE_LAST;
         5'h6: c = `NRPS_CMD_STATUS;
         5'h7: c = `NRPS_CMD_PROG_GO;
         default: c = `NRPS_CMD_READ;
      endcase
      return c;
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   nrps_state_t state_reg;
   nrps_state_t state_next;
   nrps_op_t op_reg;
   logic [2:0] step_reg;
   logic [11:0] col_reg;
   logic [17:0] row_reg;
   logic edo_reg;
   logic wp_n_reg;
   logic is_4gb_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata_reg;
   logic [7:0] sr_reg;
   logic prog_reg;
   logic [31:0] rd_reg;
   logic wait_reg;
   logic start_reg;
   logic [7:0] io_reg;
   logic oe_reg;
   logic cle_reg;
   logic ale_reg;
   logic we_n_reg;
   logic re_n_reg;
   logic ce_n_reg;
   logic [11:0] st;
   logic st_last;
   logic [1:0] st_kind;
   logic st_wait;
   logic [2:0] st_aidx;
   logic [7:0] st_cmd;
   logic [7:0] addr_byte;
   logic strobe_low;
   logic strobe_done;
   logic busy;
   logic op_ok;
   logic go_wr;
   logic sel_ctrl;
   logic sel_lo;
   logic sel_hi;
   logic sel_data;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_view;
   logic cap_now;
   logic dout_kind;
   nrps_op_t new_op;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign st = step_of(op_reg, step_reg);
   assign st_last = st[11];
   assign st_kind = st[10:9];
   assign st_wait = st[8];
   assign st_aidx = st[7:5];
   assign st_cmd = cmd_code(st[4:0], op_reg);
   assign dout_kind = (st_kind == 2'h3);
   assign busy = (state_reg != NRPS_ST_IDLE);
   assign sel_ctrl = (i_avs_address == `NRPS_OFS_CTRL);
   assign sel_lo = (i_avs_address == `NRPS_OFS_ADDR_LO);
   assign sel_hi = (i_avs_address == `NRPS_OFS_ADDR_HI);
   assign sel_data = (i_avs_address == `NRPS_OFS_DATA);
   assign new_op = nrps_op_t'(i_avs_writedata[`NRPS_CTRL_OP_MSB:`NRPS_CTRL_OP_LSB]);
   assign op_ok = !((new_op == NRPS_OP_PROG_START || new_op == NRPS_OP_PROG_GO)
                    && !i_avs_writedata[`NRPS_CTRL_WPN_BIT]);
   // Page order and partial counts are left to software
   // the sequencer programs whatever page it is given
   // No op, status included, starts while programming: busy blocks go_wr, and prog_reg is set only while busy
   assign go_wr = i_avs_write && !wait_reg && sel_ctrl && !busy && op_ok
                  && i_avs_writedata[`NRPS_CTRL_GO_BIT]
                  && (!prog_reg || new_op == NRPS_OP_STATUS);
   // Sample while the read strobe is still low; the flash holds the byte
   assign cap_now = (state_reg == NRPS_ST_CYCLE) && dout_kind
                    && (edo_reg ? strobe_done : !re_n_reg);
   // Status byte rides in the top byte of the control word
   assign ctrl_view = {sr_reg, 6'h00, !i_rb_n, busy, 5'h00, is_4gb_reg, wp_n_reg, edo_reg,
                       op_reg, 4'h0};
   assign rd_mux = sel_ctrl ? ctrl_view :
                   sel_lo ? {20'h00000, col_reg} :
                   sel_hi ? {14'h0000, row_reg} :
                   sel_data ? {24'h000000, rdata_reg} : 32'h00000000;

   nrps_addr_fmt u_addr (
      .i_col(col_reg),
      .i_row(row_reg),
      .i_is_4gb(is_4gb_reg),
      .i_idx(st_aidx),
      .o_byte(addr_byte)
   );

   // One strobe timer serves write and read cycles alike
   nrps_strobe u_strobe (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_start(start_reg),
      .o_low(strobe_low),
      .o_done(strobe_done)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         NRPS_ST_IDLE: if (go_wr) state_next = NRPS_ST_CYCLE;
         NRPS_ST_CYCLE: if (strobe_done) state_next = NRPS_ST_NEXT;
         NRPS_ST_NEXT: state_next = st_last ? (st_wait ? NRPS_ST_WAIT_RB : NRPS_ST_DONE)
                                            : NRPS_ST_CYCLE;
         NRPS_ST_WAIT_RB: if (i_rb_n) state_next = NRPS_ST_DONE;
         NRPS_ST_DONE: state_next = NRPS_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= NRPS_ST_IDLE;
         step_reg <= 3'h0;
         start_reg <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
         start_reg <= (state_next == NRPS_ST_CYCLE) && (state_reg != NRPS_ST_CYCLE);
         if (state_reg == NRPS_ST_IDLE) begin
            step_reg <= 3'h0;
         end else if (state_reg == NRPS_ST_NEXT) begin
            step_reg <= step_reg + 3'h1;
         end
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         op_reg <= NRPS_OP_PAGE_READ;
         edo_reg <= 1'b0;
         wp_n_reg <= 1'b0;
         is_4gb_reg <= 1'b0;
         col_reg <= 12'h000;
         row_reg <= 18'h00000;
         wdata_reg <= 8'h00;
      end else if (i_ce && i_avs_write && !wait_reg && !busy) begin
         if (sel_ctrl) begin
            edo_reg <= i_avs_writedata[`NRPS_CTRL_EDO_BIT];
            wp_n_reg <= i_avs_writedata[`NRPS_CTRL_WPN_BIT];
            is_4gb_reg <= i_avs_writedata[`NRPS_CTRL_4GB_BIT];
            if (go_wr) op_reg <= new_op;
         end
         if (sel_lo) col_reg <= i_avs_writedata[11:0];
         if (sel_hi) row_reg <= i_avs_writedata[17:0];
         if (sel_data) wdata_reg <= i_avs_writedata[7:0];
      end
   end

   // Held off while busy so software never races the sequencer
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wait_reg <= 1'b1;
         rd_reg <= 32'h00000000;
      end else if (i_ce) begin
         wait_reg <= !((i_avs_read || i_avs_write) && wait_reg && !busy);
         if (i_avs_read && wait_reg) rd_reg <= rd_mux;
      end
   end

   // ----------------------------------------
   // Pin drive and data capture
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cle_reg <= 1'b0;
         ale_reg <= 1'b0;
         we_n_reg <= 1'b1;
         re_n_reg <= 1'b1;
         ce_n_reg <= 1'b1;
         io_reg <= 8'h00;
         oe_reg <= 1'b0;
         rdata_reg <= 8'h00;
         sr_reg <= 8'h00;
         prog_reg <= 1'b0;
      end else if (i_ce) begin
         // Chip enable kept low through waits
         ce_n_reg <= !busy && !go_wr;
         cle_reg <= (state_reg == NRPS_ST_CYCLE) && (st_kind == 2'h0);
         ale_reg <= (state_reg == NRPS_ST_CYCLE) && (st_kind == 2'h1);
         we_n_reg <= !(strobe_low && !dout_kind && state_reg == NRPS_ST_CYCLE);
         // One falling read strobe per byte
         re_n_reg <= !(strobe_low && dout_kind && state_reg == NRPS_ST_CYCLE);
         oe_reg <= (state_reg == NRPS_ST_CYCLE) && !dout_kind;
         io_reg <= (st_kind == 2'h0) ? st_cmd : (st_kind == 2'h1) ? addr_byte : wdata_reg;
         // Byte taken only in a data-out cycle
         if (cap_now) begin
            rdata_reg <= i_io;
            if (op_reg == NRPS_OP_STATUS) sr_reg <= i_io;
         end
         if (state_reg == NRPS_ST_NEXT && st_last && op_reg == NRPS_OP_PROG_GO)
            prog_reg <= 1'b1;
         else if (i_rb_n && state_reg == NRPS_ST_DONE)
            prog_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------
   assign o_avs_readdata = rd_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_ce_n = ce_n_reg;
   assign o_cle = cle_reg;
   assign o_ale = ale_reg;
   assign o_we_n = we_n_reg;
   assign o_read_strobe_n = re_n_reg;
   assign o_wp_n = wp_n_reg;
   assign o_io = io_reg;
   assign o_io_oe = oe_reg;
endmodule

// >>> nrps_host_asserts.sv
`timescale 1ns/1ps
`include "nrps_defines.svh"
// ---
// Port checker
// ---
module nrps_host_asserts (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_ce_n,
   input wire logic o_cle,
   input wire logic o_ale,
   input wire logic o_we_n,
   input wire logic o_read_strobe_n,
   input wire logic o_wp_n,
   input wire logic [7:0] i_io,
   input wire logic [7:0] o_io,
   input wire logic o_io_oe,
   input wire logic i_rb_n
);
   logic [2:0] acnt;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // Address byte index since the last command
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         acnt <= 3'h0;
      end else if ($rose(o_we_n)) begin
         acnt <= o_cle ? 3'h0 : acnt + {2'h0, o_ale};
      end
   end
   chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   chk_we_pulse: assert property ($fell(o_we_n) |=> $rose(o_we_n))
      else $error("write strobe not one cycle low");
   chk_bus_setup: assert property ($fell(o_we_n) |-> o_io_oe && !o_ce_n && $stable(o_io))
      else $error("bus not set up before write strobe");
   chk_latch_excl: assert property (!(o_cle && o_ale))
      else $error("both latch enables high");
   chk_read_free: assert property (!o_read_strobe_n |-> !o_io_oe && !o_cle && !o_ale)
      else $error("bus driven during read strobe");
   chk_ce_strobe: assert property (o_ce_n |-> o_we_n && o_read_strobe_n)
      else $error("strobe while chip deselected");
   chk_read_ready: assert property ($fell(o_read_strobe_n) |-> i_rb_n)
      else $error("read strobe while flash busy");
   chk_col_high: assert property ($rose(o_we_n) && o_ale && acnt == 3'h1 |-> o_io[7:4] == 4'h0)
      else $error("second address byte upper bits set");
   chk_row_top: assert property ($rose(o_we_n) && o_ale && acnt == 3'h4 |-> o_io[7:2] == 6'h00)
      else $error("fifth address byte upper bits set");
   chk_prog_wp: assert property ($rose(o_we_n) && o_cle && o_io == `NRPS_CMD_PROG_GO |-> o_wp_n)
      else $error("program confirm sent while protected");
endmodule

// >>> nrps_flash_model.sv
`timescale 1ns/1ps
// ---
// Flash device model
// ---
module nrps_flash_model #(
   parameter int T_BUSY = 3000,
   parameter logic [17:0] FAIL_ROW = 18'h00077
) (
   input wire logic i_ce_n,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_we_n,
   input wire logic i_read_strobe_n,
   input wire logic i_wp_n,
   input wire logic [7:0] i_din,
   output logic [7:0] o_dq,
   output logic o_rb_n
);
   logic [7:0] mem [int];
   logic [7:0] pbuf [int];
   logic [7:0] ab [1:5];
   logic [7:0] dq = 8'hFF;
   logic [17:0] row = 18'h0;
   logic [11:0] col = 12'h0;
   logic busy = 1'b0, prog = 1'b0, stat = 1'b0, fail = 1'b0, ld = 1'b0, got = 1'b0;
   int na = 0;
   event kick;
   // Released bus shows the inverse, never a stale byte
   assign o_dq = i_ce_n ? ~dq : dq;
   // Busy whole interval, chip enable ignored
   assign o_rb_n = !busy;
   always @(kick) begin
      #(prog ? 2 * T_BUSY : T_BUSY);
      busy = 1'b0;
      prog = 1'b0;
   end
   function automatic logic [7:0] pat(input logic [17:0] r, input logic [11:0] c);
      return r[7:0] ^ c[7:0] ^ {4'hA, c[11:8]};
   endfunction
   task automatic start(input logic p);
      busy = 1'b1;
      prog = p;
      got = 1'b0;
      na = 0;
      -> kick;
   endtask
   always @(posedge i_we_n) begin
      if (i_ce_n || (prog && !(i_cle && i_din == 8'h70))) begin
      end else if (i_cle) begin
         case (i_din)
            8'h00, 8'h05, 8'h85: begin
               na = 0;
               stat = 1'b0;
            end
            8'h30: start(1'b0);
            8'h31, 8'h3F: begin
               if (!got) row = row + 18'h1;
               col = 12'h0;
               start(1'b0);
            end
            8'h70: stat = 1'b1;
            8'h80: if (i_wp_n) begin
               ld = 1'b1;
               pbuf.delete();
               na = 0;
            end
            8'h10: if (ld && i_wp_n) begin
               foreach (pbuf[c]) mem[{row, c[11:0]}] = pbuf[c];
               fail = (row == FAIL_ROW);
               ld = 1'b0;
               start(1'b1);
            end
            default: ;
         endcase
      end else if (i_ale) begin
         if (na < 5) na = na + 1;
         ab[na] = i_din;
         // Column then row, plane bit kept in row
         if (na == 2) col = {ab[2][3:0], ab[1]};
         if (na == 5) begin
            row = {ab[5][1:0], ab[4], ab[3]};
            got = 1'b1;
         end
      end else if (ld) begin
         pbuf[col] = i_din;
         col = col + 12'h1;
      end
   end
   // Falling read strobe presents; page reads also advance the column, status reads do not
   always @(negedge i_read_strobe_n) begin
      if (!i_ce_n && stat) begin
         dq = {1'b0, !busy, !busy, 4'h0, fail};
      end else if (!i_ce_n) begin
         dq = mem.exists({row, col}) ? mem[{row, col}] : pat(row, col);
         col = (col == 12'h86F) ? 12'h0 : col + 12'h1;
      end
   end
endmodule

// >>> nrps_host_tb.sv
`timescale 1ns/1ps
`include "nrps_defines.svh"
// ---
// Testbench
// ---
module nrps_host_tb;
   import nrps_pkg::*;
   localparam logic [17:0] FROW = 18'h00077;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [3:0] i_avs_address = 4'h0;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, s;
   logic o_avs_waitrequest, o_ce_n, o_cle, o_ale, o_we_n, o_read_strobe_n, o_wp_n, o_io_oe, rb_n;
   logic [7:0] o_io, fl_io, i_io;
   int n_fail = 0, check_count = 0;
   assign i_io = o_io_oe ? o_io : fl_io;
   nrps_host u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
      .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n), .i_io(i_io),
      .o_io(o_io), .o_io_oe(o_io_oe), .i_rb_n(rb_n));
   nrps_flash_model #(.FAIL_ROW(FROW)) u_flash (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
      .i_we_n(o_we_n), .i_read_strobe_n(o_read_strobe_n), .i_wp_n(o_wp_n), .i_din(o_io),
      .o_dq(fl_io), .o_rb_n(rb_n));
   initial forever #25 i_clk_sys = ~i_clk_sys;
   task automatic end_sim;
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                      output logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_writedata <= v;
      i_avs_write <= w;
      i_avs_read <= !w;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 2000);
      d = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (n >= 2000) begin
         n_fail++;
         end_sim();
      end
   endtask
   task automatic op(input nrps_op_t o, input logic [2:0] f = 3'b001);
      logic [31:0] t;
      bus(1'b1, `NRPS_OFS_CTRL, {21'h0, f[2], f[0], f[1], o, 3'h0, 1'b1}, t);
      bus(1'b0, `NRPS_OFS_CTRL, 32'h0, t);
   endtask
   task automatic rb(input logic [7:0] e, input logic [2:0] f = 3'b001);
      logic [31:0] t;
      op(NRPS_OP_READ_BYTE, f);
      bus(1'b0, `NRPS_OFS_DATA, 32'h0, t);
      chk(t[7:0], e);
   endtask
   task automatic wb(input logic [7:0] b);
      logic [31:0] t;
      bus(1'b1, `NRPS_OFS_DATA, {24'h0, b}, t);
      op(NRPS_OP_WRITE_BYTE);
   endtask
   task automatic at(input logic [11:0] c, input logic [17:0] r);
      logic [31:0] t;
      bus(1'b1, `NRPS_OFS_ADDR_LO, {20'h0, c}, t);
      bus(1'b1, `NRPS_OFS_ADDR_HI, {14'h0, r}, t);
   endtask
   function automatic logic [7:0] pat(input logic [17:0] r, input logic [11:0] c);
      return r[7:0] ^ c[7:0] ^ {4'hA, c[11:8]};
   endfunction
   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      bus(1'b0, `NRPS_OFS_CTRL, 32'h0, s);
      chk(s, 32'h0);
      at(12'h005, 18'h00141);
      op(NRPS_OP_PAGE_READ);
      rb(pat(18'h00141, 12'h005));
      rb(pat(18'h00141, 12'h006), 3'b011);
      bus(1'b1, `NRPS_OFS_ADDR_LO, 32'h86F, s);
      op(NRPS_OP_COL_CHANGE);
      rb(pat(18'h00141, 12'h86F));
      at(12'h000, 18'h00010);
      op(NRPS_OP_PROG_START);
      wb(8'h11);
      wb(8'h22);
      bus(1'b1, `NRPS_OFS_ADDR_LO, 32'h10, s);
      op(NRPS_OP_PROG_COL);
      wb(8'h33);
      op(NRPS_OP_PROG_GO);
      op(NRPS_OP_STATUS);
      bus(1'b0, `NRPS_OFS_CTRL, 32'h0, s);
      chk(s[31:24], 8'h60);
      at(12'h000, 18'h20010);
      op(NRPS_OP_PAGE_READ);
      rb(8'h11);
      rb(8'h22);
      rb(pat(18'h00010, 12'h002));
      bus(1'b1, `NRPS_OFS_ADDR_LO, 32'h10, s);
      op(NRPS_OP_COL_CHANGE);
      rb(8'h33);
      at(12'h000, 18'h20010);
      op(NRPS_OP_PAGE_READ, 3'b101);
      rb(pat(18'h20010, 12'h000));
      at(12'h000, 18'h00020);
      op(NRPS_OP_PROG_START, 3'b000);
      wb(8'h44);
      op(NRPS_OP_PROG_GO, 3'b000);
      at(12'h000, 18'h00020);
      op(NRPS_OP_PAGE_READ);
      rb(pat(18'h00020, 12'h000));
      at(12'h000, FROW);
      op(NRPS_OP_PROG_START);
      wb(8'h5A);
      op(NRPS_OP_PROG_GO);
      op(NRPS_OP_STATUS);
      bus(1'b0, `NRPS_OFS_CTRL, 32'h0, s);
      chk(s[24], 1'b1);
      at(12'h003, 18'h0003F);
      op(NRPS_OP_PAGE_READ);
      op(NRPS_OP_CACHE_SEQ);
      rb(pat(18'h00040, 12'h000));
      op(NRPS_OP_STATUS);
      bus(1'b0, `NRPS_OFS_CTRL, 32'h0, s);
      chk(s[30:29], 2'b11);
      op(NRPS_OP_RESUME);
      rb(pat(18'h00040, 12'h001));
      op(NRPS_OP_CACHE_LAST);
      rb(pat(18'h00041, 12'h000));
      at(12'h007, 18'h00200);
      op(NRPS_OP_PAGE_READ);
      at(12'h123, 18'h01234);
      op(NRPS_OP_CACHE_RAND);
      rb(pat(18'h01234, 12'h000));
      bus(1'b0, 4'h2, 32'h0, s);
      chk(s, 32'h0);
      end_sim();
   end
endmodule
bind nrps_host nrps_host_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
   .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n), .i_io(i_io),
   .o_io(o_io), .o_io_oe(o_io_oe), .i_rb_n(i_rb_n));
